// ### rtl/xid_regs.vh
// Constants for the extended instruction decoder: opcodes, phases, addressing limits.
// Assumes a 16-bit program word and a 12-bit data memory address.
`ifndef XID_REGS_VH
`define XID_REGS_VH

`define XID_PHASE_Q1        2'h0
`define XID_PHASE_Q2        2'h1
`define XID_PHASE_Q3        2'h2
`define XID_PHASE_Q4        2'h3

`define XID_OP_XOR_HI       6'h06
`define XID_OP_ADD_PTR      8'hE8
`define XID_OP_SUB_PTR      8'hE9
`define XID_OP_PUSH_LIT     8'hEA
`define XID_OP_MOVE         8'hEB
`define XID_OP_CALL_W       16'h0014
`define XID_OP_WORD2_HI     4'hF

`define XID_SEL_RETURN      2'h3
`define XID_INDEX_LIMIT     8'h5F
`define XID_ACCESS_HI_PAGE  4'hF
`define XID_ACCESS_LO_PAGE  4'h0

`define XID_RST_PTR         12'h000
`define XID_RST_WORKING_REGISTER        8'h00

`endif

// ### rtl/xid_qphase.v
// Quarter-cycle phase generator: Q1..Q4 repeat, one clock each.
// Assumes one core clock; phase restarts at Q1 after reset.
`include "xid_regs.vh"

module xid_qphase (
  input  wire       clk,
  input  wire       rst_n,
  output wire [1:0] phase
);
  reg [1:0] phase_reg;
  wire [1:0] phase_next;

  assign phase_next = phase_reg + 2'h1;
  assign phase      = phase_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= `XID_PHASE_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end
endmodule

// ### rtl/xid_decoder.v
// Extended instruction decoder and executor for an 8-bit core.
// Assumes program memory holds prog_word stable through Q1 for address prog_addr,
// and data memory returns read data one clock after a read strobe.
// Functional notes
// - Extended behaviour stays off from reset and turns on only with the fuse set.
// - Standard opcodes decode always and the five extended opcodes only with the extension on.
// - Add or subtract a 6-bit literal to the chosen pointer in one cycle.
// - Add with selector 3 adds to pointer two, returns via stack top, two cycles, no flags.
// - Subtract with selector 3 subtracts from pointer two and returns, two cycles, no flags.
// - Opcode 0014h calls a target built from the working register in two cycles, no flags.
// - Move indexed-to-absolute copies the pointer-two source to a 12-bit address in two cycles.
// - Move indexed-to-indexed copies between two pointer-two locations in two cycles.
// - Push literal writes the byte at pointer two and then decrements it in one cycle.
// - Standard byte instructions may address relative to pointer two with the extension on.
// - Indexed addressing applies only with access bit 0, extension on and operand up to 5Fh.
// - Exclusive-or decodes in Q1, reads in Q2, computes in Q3 and writes in Q4.
`include "xid_regs.vh"

module xid_decoder #(
  parameter PC_W = 21
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              extension_enable_fuse,
  input  wire [15:0]       prog_word,
  output wire [PC_W-1:0]   prog_addr,
  input  wire [PC_W-1:0]   top_of_return_stack,
  output wire              stack_push,
  output wire              stack_pop,
  output wire [PC_W-1:0]   stack_push_data,
  input  wire [PC_W-9:0]   pc_latch_hi,
  input  wire [3:0]        bank_select,
  output wire [11:0]       dmem_addr,
  output wire              dmem_rd,
  input  wire [7:0]        dmem_rdata,
  output wire              dmem_wr,
  output wire [7:0]        dmem_wdata,
  output wire [7:0]        working_register,
  output wire [11:0]       pointer_two,
  output wire              flag_zero,
  output wire              flag_negative,
  output wire              extension_active,
  output wire [1:0]        phase
);
  localparam ST_FIRST = 2'h0;
  localparam ST_NOP   = 2'h1;
  localparam ST_MOVE  = 2'h2;

  reg              fuse_s1_reg;
  reg              fuse_s2_reg;
  reg              ext_reg;
  reg [1:0]        state_reg;
  reg [15:0]       ir_reg;
  reg [15:0]       word2_reg;
  reg [PC_W-1:0]   pc_reg;
  reg [11:0]       ptr_reg [0:2];
  reg [7:0]        working_register_reg;
  reg [7:0]        opnd_reg;
  reg [7:0]        result_reg;
  reg              z_reg;
  reg              n_reg;
  reg [11:0]       dmem_addr_reg;
  reg              dmem_rd_reg;
  reg              dmem_wr_reg;
  reg [7:0]        dmem_wdata_reg;
  reg              push_reg;
  reg              pop_reg;
  reg [PC_W-1:0]   push_data_reg;

  wire [1:0]       ph;
  wire [15:0]      ir_now;
  wire [15:0]      w2_now;
  wire             dec_xor;
  wire             dec_add;
  wire             dec_sub;
  wire             dec_push;
  wire             dec_move;
  wire             dec_call;
  wire [1:0]       fsel;
  wire [11:0]      k6;
  wire             ret_variant;
  wire [11:0]      move_dest;
  wire [PC_W-1:0]  pc_inc;

  xid_qphase u_qphase (
    .clk   (clk),
    .rst_n (rst_n),
    .phase (ph)
  );

  // Pointer-two relative address from an unsigned offset.
  function [11:0] idx_addr;
    input [11:0] base;
    input [7:0]  off;
    begin
      idx_addr = base + {4'h0, off};
    end
  endfunction

  // Operand address of a byte instruction.
  function [11:0] file_addr;
    input [7:0]  f;
    input        a;
    input        ext;
    input [11:0] base;
    input [3:0]  bank;
    begin
      if (!a && ext && (f <= `XID_INDEX_LIMIT)) begin
        file_addr = idx_addr(base, f);
      end else if (a) begin
        file_addr = {bank, f};
      end else if (f > `XID_INDEX_LIMIT) begin
        file_addr = {`XID_ACCESS_HI_PAGE, f};
      end else begin
        file_addr = {`XID_ACCESS_LO_PAGE, f};
      end
    end
  endfunction

  // Word seen in Q1 comes straight from program memory, later from the latch.
  assign ir_now  = (ph == `XID_PHASE_Q1 && state_reg == ST_FIRST) ? prog_word : ir_reg;
  assign w2_now  = (ph == `XID_PHASE_Q1) ? prog_word : word2_reg;

  assign dec_xor  = (ir_now[15:10] == `XID_OP_XOR_HI);
  assign dec_add  = ext_reg && (ir_now[15:8] == `XID_OP_ADD_PTR);
  assign dec_sub  = ext_reg && (ir_now[15:8] == `XID_OP_SUB_PTR);
  assign dec_push = ext_reg && (ir_now[15:8] == `XID_OP_PUSH_LIT);
  assign dec_move = ext_reg && (ir_now[15:8] == `XID_OP_MOVE);
  assign dec_call = ext_reg && (ir_now == `XID_OP_CALL_W);

  assign fsel        = ir_now[7:6];
  assign k6          = {6'h00, ir_now[5:0]};
  assign ret_variant = (fsel == `XID_SEL_RETURN);
  assign pc_inc      = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};

  assign move_dest = ir_reg[7] ? idx_addr(ptr_reg[2], {1'b0, w2_now[6:0]}) : w2_now[11:0];

  assign prog_addr        = pc_reg;
  assign stack_push       = push_reg;
  assign stack_pop        = pop_reg;
  assign stack_push_data  = push_data_reg;
  assign dmem_addr        = dmem_addr_reg;
  assign dmem_rd          = dmem_rd_reg;
  assign dmem_wr          = dmem_wr_reg;
  assign dmem_wdata       = dmem_wdata_reg;
  assign working_register = working_register_reg;
  assign pointer_two      = ptr_reg[2];
  assign flag_zero        = z_reg;
  assign flag_negative    = n_reg;
  assign extension_active = ext_reg;
  assign phase            = ph;

  always @(posedge clk) begin
    if (!rst_n) begin
      fuse_s1_reg    <= 1'b0;
      fuse_s2_reg    <= 1'b0;
      ext_reg        <= 1'b0;
      state_reg      <= ST_FIRST;
      ir_reg         <= 16'h0000;
      word2_reg      <= 16'h0000;
      pc_reg         <= {PC_W{1'b0}};
      ptr_reg[0]     <= `XID_RST_PTR;
      ptr_reg[1]     <= `XID_RST_PTR;
      ptr_reg[2]     <= `XID_RST_PTR;
      working_register_reg       <= `XID_RST_WORKING_REGISTER;
      opnd_reg       <= 8'h00;
      result_reg     <= 8'h00;
      z_reg          <= 1'b0;
      n_reg          <= 1'b0;
      dmem_addr_reg  <= 12'h000;
      dmem_rd_reg    <= 1'b0;
      dmem_wr_reg    <= 1'b0;
      dmem_wdata_reg <= 8'h00;
      push_reg       <= 1'b0;
      pop_reg        <= 1'b0;
      push_data_reg  <= {PC_W{1'b0}};
    end else begin
      fuse_s1_reg <= extension_enable_fuse;
      fuse_s2_reg <= fuse_s1_reg;
      if (ph == `XID_PHASE_Q4 && state_reg == ST_FIRST) begin
        ext_reg <= fuse_s2_reg;
      end
      case (ph)
        `XID_PHASE_Q1: begin
          if (state_reg == ST_FIRST) begin
            ir_reg <= prog_word;
            if (dec_xor) begin
              dmem_rd_reg   <= 1'b1;
              dmem_addr_reg <= file_addr(ir_now[7:0], ir_now[8], ext_reg, ptr_reg[2],
                                         bank_select);
            end else if (dec_move) begin
              dmem_rd_reg   <= 1'b1;
              dmem_addr_reg <= idx_addr(ptr_reg[2], {1'b0, ir_now[6:0]});
            end
          end else if (state_reg == ST_MOVE) begin
            word2_reg <= prog_word;
          end
        end
        `XID_PHASE_Q2: begin
          dmem_rd_reg <= 1'b0;
        end
        `XID_PHASE_Q3: begin
          if (state_reg == ST_FIRST) begin
            opnd_reg <= dmem_rdata;
            if (dec_xor) begin
              result_reg <= working_register_reg ^ dmem_rdata;
              if (ir_reg[9]) begin
                dmem_wr_reg    <= 1'b1;
                dmem_wdata_reg <= working_register_reg ^ dmem_rdata;
              end
            end else if (dec_push) begin
              dmem_wr_reg    <= 1'b1;
              dmem_addr_reg  <= ptr_reg[2];
              dmem_wdata_reg <= ir_reg[7:0];
            end else if ((dec_add || dec_sub) && ret_variant) begin
              pop_reg <= 1'b1;
            end else if (dec_call) begin
              push_reg      <= 1'b1;
              push_data_reg <= pc_inc;
            end
          end else if (state_reg == ST_MOVE) begin
            dmem_wr_reg    <= 1'b1;
            dmem_addr_reg  <= move_dest;
            dmem_wdata_reg <= opnd_reg;
          end
        end
        default: begin
          dmem_wr_reg <= 1'b0;
          push_reg    <= 1'b0;
          pop_reg     <= 1'b0;
          case (state_reg)
            ST_FIRST: begin
              pc_reg <= pc_inc;
              state_reg <= ST_FIRST;
              if (dec_xor) begin
                if (!ir_reg[9]) begin
                  working_register_reg <= result_reg;
                end
                z_reg <= (result_reg == 8'h00);
                n_reg <= result_reg[7];
              end
              if (dec_add) begin
                if (ret_variant) begin
                  ptr_reg[2] <= ptr_reg[2] + k6;
                  pc_reg     <= top_of_return_stack;
                  state_reg  <= ST_NOP;
                end else begin
                  ptr_reg[fsel] <= ptr_reg[fsel] + k6;
                end
              end
              if (dec_sub) begin
                if (ret_variant) begin
                  ptr_reg[2] <= ptr_reg[2] - k6;
                  pc_reg     <= top_of_return_stack;
                  state_reg  <= ST_NOP;
                end else begin
                  ptr_reg[fsel] <= ptr_reg[fsel] - k6;
                end
              end
              if (dec_push) begin
                ptr_reg[2] <= ptr_reg[2] - 12'h001;
              end
              if (dec_call) begin
                pc_reg    <= {pc_latch_hi, working_register_reg};
                state_reg <= ST_NOP;
              end
              if (dec_move) begin
                state_reg <= ST_MOVE;
              end
            end
            ST_MOVE: begin
              pc_reg    <= pc_inc;
              state_reg <= ST_FIRST;
            end
            default: begin
              state_reg <= ST_FIRST;
            end
          endcase
        end
      endcase
    end
  end
endmodule

// ### testbench/xid_decoder_props.sv
// Checker for the extended instruction decoder, watching its top-level ports only.
// Assumes a single clock with a synchronous active-low reset.
module xid_decoder_props #(
  parameter PC_W = 21
) (
  input logic            clk,
  input logic            rst_n,
  input logic            extension_enable_fuse,
  input logic [PC_W-1:0] prog_addr,
  input logic [PC_W-1:0] top_of_return_stack,
  input logic            stack_push,
  input logic            stack_pop,
  input logic [PC_W-9:0] pc_latch_hi,
  input logic            dmem_rd,
  input logic            dmem_wr,
  input logic [7:0]      working_register,
  input logic [11:0]     pointer_two,
  input logic            flag_zero,
  input logic            flag_negative,
  input logic            extension_active,
  input logic [1:0]      phase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_phase_order: assert property (
    phase == 2'h0 |=> phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3)
    else $error("phase order broken");
  a_read_q2: assert property (
    dmem_rd |-> phase == 2'h1 ##1 !dmem_rd) else $error("read strobe misplaced");
  a_write_q4: assert property (
    dmem_wr |-> phase == 2'h3) else $error("write strobe outside Q4");
  a_pc_boundary: assert property (
    !$stable(prog_addr) |-> phase == 2'h0) else $error("program address moved mid-cycle");
  a_call_target: assert property (
    stack_push |-> phase == 2'h3 && !stack_pop ##1
    prog_addr == {$past(pc_latch_hi), $past(working_register)})
    else $error("call target wrong");
  a_return_target: assert property (
    stack_pop |=> prog_addr == $past(top_of_return_stack)) else $error("return target wrong");
  a_return_flags: assert property (
    stack_pop |=> $stable(flag_zero) && $stable(flag_negative)) else $error("return hit flags");
  a_off_pointer: assert property (
    !extension_active |-> $stable(pointer_two)) else $error("pointer moved while off");
  a_fuse_off: assert property (
    !extension_enable_fuse [*8] |-> !extension_active) else $error("extension on without fuse");

  c_call: cover property (stack_push);
  c_return: cover property (stack_pop);
  c_ext_write: cover property (dmem_wr && extension_active);
endmodule

// ### testbench/xid_mem_model.sv
// Program and data memory of the core as seen by the decoder.
// Assumes read data is wanted one clock after the read strobe.
module xid_mem_model #(
  parameter PC_W = 21
) (
  input  logic            clk,
  input  logic [PC_W-1:0] prog_addr,
  output logic [15:0]     prog_word,
  input  logic [11:0]     dmem_addr,
  input  logic            dmem_rd,
  output logic [7:0]      dmem_rdata,
  input  logic            dmem_wr,
  input  logic [7:0]      dmem_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] pmem [0:4095];
  logic [7:0]  dmem [0:4095];
  logic [11:0] last_wr_addr;

  assign prog_word = pmem[prog_addr[11:0]];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      pmem[i] = 16'h0000;
      dmem[i] = 8'h00;
    end
    dmem_rdata = 8'h00;
    last_wr_addr = 12'h000;
  end
  // Outside a read the data lines keep changing so a late sample cannot pass by luck.
  always @(posedge clk) begin
    dmem_rdata <= dmem_rd ? dmem[dmem_addr] : ~dmem_rdata;
    if (dmem_wr) begin
      dmem[dmem_addr] <= dmem_wdata;
      last_wr_addr <= dmem_addr;
    end
  end
endmodule

// ### testbench/xid_decoder_bench.sv
// Self-checking bench for the extended instruction decoder with its memory model.
// Assumes the decoder restarts at program address 0 in Q1 after reset.
module xid_decoder_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC_W = 21;
  logic            clk, rst_n, extension_enable_fuse, stack_push, stack_pop;
  logic            dmem_rd, dmem_wr, flag_zero, flag_negative, extension_active;
  logic [15:0]     prog_word;
  logic [PC_W-1:0] prog_addr, top_of_return_stack, stack_push_data, pushed, last_pc;
  logic [PC_W-9:0] pc_latch_hi;
  logic [3:0]      bank_select;
  logic [11:0]     dmem_addr, pointer_two;
  logic [7:0]      dmem_rdata, dmem_wdata, working_register;
  logic [1:0]      phase;
  int              error_cnt = 0;
  int              compares = 0;

  xid_decoder #(.PC_W(PC_W)) dut_u (.clk(clk), .rst_n(rst_n),
    .extension_enable_fuse(extension_enable_fuse), .prog_word(prog_word),
    .prog_addr(prog_addr), .top_of_return_stack(top_of_return_stack),
    .stack_push(stack_push), .stack_pop(stack_pop), .stack_push_data(stack_push_data),
    .pc_latch_hi(pc_latch_hi), .bank_select(bank_select), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
    .working_register(working_register), .pointer_two(pointer_two), .flag_zero(flag_zero),
    .flag_negative(flag_negative), .extension_active(extension_active), .phase(phase));
  xid_mem_model #(.PC_W(PC_W)) mdl_u (.clk(clk), .prog_addr(prog_addr),
    .prog_word(prog_word), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (stack_push === 1'b1) pushed <= stack_push_data;

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Places one word at the address about to be fetched and lets its cycle run out.
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    while (phase !== 2'h0 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      report_and_stop();
    end
    last_pc = prog_addr;
    mdl_u.pmem[prog_addr[11:0]] = w;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_ext_off();
    mdl_u.dmem[12'h002] = 8'h33;
    exec(16'hE885);
    chk("pointer_two", 32'h000, pointer_two);
    exec(16'h1A02);
    chk("write address", 32'h002, mdl_u.last_wr_addr);
    chk("extension_active", 32'h0, extension_active);
  endtask
  task automatic t_ext_on_pointers();
    extension_enable_fuse = 1'b1;
    repeat (3) exec(16'h0000);
    chk("extension_active", 32'h1, extension_active);
    exec(16'hE8BF);
    chk("pointer_two", 32'h03F, pointer_two);
    exec(16'hE805);
    chk("pointer_two", 32'h03F, pointer_two);
    exec(16'hE981);
    chk("pointer_two", 32'h03E, pointer_two);
    exec(16'hEA5A);
    chk("pointer_two", 32'h03D, pointer_two);
    chk("pushed byte", 32'h5A, mdl_u.dmem[12'h03E]);
  endtask
  task automatic t_xor_indexed();
    bank_select = 4'h1;
    mdl_u.dmem[12'h110] = 8'hB5;
    mdl_u.dmem[12'h03F] = 8'hAF;
    mdl_u.dmem[12'hF60] = 8'hB5;
    exec(16'h1910);
    chk("working_register", 32'hB5, working_register);
    chk("flag_negative", 32'h1, flag_negative);
    chk("flag_zero", 32'h0, flag_zero);
    exec(16'h1A02);
    chk("indexed result", 32'h1A, mdl_u.dmem[12'h03F]);
    chk("flag_negative", 32'h0, flag_negative);
    exec(16'h1A60);
    chk("access result", 32'h00, mdl_u.dmem[12'hF60]);
    chk("flag_zero", 32'h1, flag_zero);
  endtask
  task automatic t_moves();
    exec(16'hEB01);
    exec(16'hF123);
    chk("absolute dest", 32'h5A, mdl_u.dmem[12'h123]);
    exec(16'hEB81);
    exec(16'hF002);
    chk("indexed dest", 32'h5A, mdl_u.dmem[12'h03F]);
  endtask
  task automatic t_call_return();
    pc_latch_hi = 13'h0001;
    top_of_return_stack = 21'h00ABC;
    exec(16'h0014);
    chk("call target", 32'h001B5, prog_addr);
    chk("return address", last_pc + 21'h1, pushed);
    exec(16'h0000);
    exec(16'hE8C1);
    chk("return target", 32'h00ABC, prog_addr);
    chk("pointer_two", 32'h03E, pointer_two);
    exec(16'h0000);
    exec(16'hE9C2);
    chk("return target", 32'h00ABC, prog_addr);
    chk("pointer_two", 32'h03C, pointer_two);
    chk("flag_zero", 32'h1, flag_zero);
    exec(16'h0000);
  endtask
  // Pointer two is non-zero here, so a leftover indexed access would show.
  task automatic t_ext_revoke();
    extension_enable_fuse = 1'b0;
    repeat (3) exec(16'h0000);
    chk("extension_active", 32'h0, extension_active);
    exec(16'hE885);
    chk("pointer_two", 32'h03C, pointer_two);
    exec(16'h1A02);
    chk("write address", 32'h002, mdl_u.last_wr_addr);
  endtask

  initial begin
    rst_n = 1'b0;
    extension_enable_fuse = 1'b0;
    top_of_return_stack = 21'h000000;
    pc_latch_hi = 13'h0000;
    bank_select = 4'h0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_ext_off();
    t_ext_on_pointers();
    t_xor_indexed();
    t_moves();
    t_call_return();
    t_ext_revoke();
    report_and_stop();
  end
endmodule

bind xid_decoder xid_decoder_props #(.PC_W(PC_W)) chk_u (.clk(clk), .rst_n(rst_n),
  .extension_enable_fuse(extension_enable_fuse), .prog_addr(prog_addr),
  .top_of_return_stack(top_of_return_stack), .stack_push(stack_push),
  .stack_pop(stack_pop), .pc_latch_hi(pc_latch_hi), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
  .working_register(working_register), .pointer_two(pointer_two), .flag_zero(flag_zero),
  .flag_negative(flag_negative), .extension_active(extension_active), .phase(phase));
